/* File: hw/lpc_host_if_pin_monitor_ctrl.sv */
// Pin monitor and channel control registers of the LPC host interface slave.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "lpc_pin_monitor_ctrl_defines.svh"

// Overview of operation
// - Top control bit steers channel 1/2 address writes.
// - BT wait code five short, six long.
// - KCS enable counts only while channel3 enable low.
// - KCS disabled blocks channel 3 KCS matches only while channel3 enable low.
// - SMIC enable counts only while channel3 enable low.
// - SMIC disabled blocks channel 3 SMIC matches only while channel3 enable low.
module lpc_host_if_pin_monitor_ctrl
  import lpc_pin_monitor_ctrl_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  // Register port.
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [7:0]        o_reg_rdata,
  // Pin levels, all from outside the clock domain.
  input  wire logic              i_lframe_n,
  input  wire logic              i_clkrun_n,
  input  wire logic              i_serirq,
  input  wire logic              i_lreset_n,
  input  wire logic              i_lpcpd_n,
  input  wire logic              i_pme_n,
  input  wire logic              i_smi_output_pin_n,
  input  wire logic              i_sci_output_pin_n,
  // Address setting strobe from the channel address logic.
  input  wire logic              i_chan_addr_wr,
  output logic                   o_channel1_address_wr,
  output logic                   o_channel2_address_wr,
  // Raw channel 3 address hits from the LPC decoder.
  input  wire logic              i_kcs_addr_hit,
  input  wire logic              i_smic_addr_hit,
  output logic                   o_kcs_match,
  output logic                   o_smic_match,
  // Wait code for the BT synchronisation field.
  output logic      [3:0]        o_bt_wait_code,
  output logic                   o_address_channel_select
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // An interface enable bit only counts while channel3_enable is low; with
  // channel3_enable high the bit is ignored and the interface is left ungated.
  function automatic logic if_active(input logic en, input logic ch3_en);
    if_active = ch3_en | en;
  endfunction

  // Local address compare, narrowed to the port width.
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [7:0] pins_async;
  logic [7:0] pins_sync;

  // Bit order is the order of the monitor register, bit 7 first.
  assign pins_async = {i_lframe_n, i_clkrun_n, i_serirq, i_lreset_n,
                       i_lpcpd_n, i_pme_n, i_smi_output_pin_n, i_sci_output_pin_n};

  pin_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_async   (pins_async),
    .o_sync    (pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  bank_state_type s_reg;
  bank_state_type s_next;
  logic           kcs_active;
  logic           smic_active;
  logic           addr_sel;
  logic           wait_sel;

  assign addr_sel    = s_reg.ctrl[`CTRL_ADDR_SEL_BIT];
  assign wait_sel    = s_reg.ctrl[`CTRL_BT_WAIT_BIT];
  assign kcs_active  = if_active(s_reg.ctrl[`CTRL_KCS_EN_BIT],
                                 s_reg.host_if_ctrl0[`CH3_ENABLE_BIT]);
  assign smic_active = if_active(s_reg.ctrl[`CTRL_SMIC_EN_BIT],
                                 s_reg.host_if_ctrl0[`CH3_ENABLE_BIT]);

  // Next-state logic: register writes, read data, steering and gating.
  always_comb begin
    s_next = s_reg;

    // Reserved bits of the control register are stored as written; host_if_ctrl0 keeps only bit 0. Software is expected to keep them zero.
    if (i_reg_wr) begin
      if (addr_is(i_reg_addr, `OFF_CHANNEL_CTRL)) begin
        s_next.ctrl = i_reg_wdata;
      end else if (addr_is(i_reg_addr, `OFF_HOST_IF_CTRL0)) begin
        s_next.host_if_ctrl0 = {7'h00, i_reg_wdata[`CH3_ENABLE_BIT]};
      end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads give zero.
    s_next.rdata = `RDATA_RESET;
    if (i_reg_rd) begin
      if (addr_is(i_reg_addr, `OFF_PIN_MONITOR)) begin
        s_next.rdata = pins_sync;
      end else if (addr_is(i_reg_addr, `OFF_CHANNEL_CTRL)) begin
        s_next.rdata = s_reg.ctrl;
      end else if (addr_is(i_reg_addr, `OFF_HOST_IF_CTRL0)) begin
        s_next.rdata = s_reg.host_if_ctrl0;
      end
    end

    // Address settings go to exactly one channel address register.
    s_next.ch1_addr_wr = i_chan_addr_wr & ~addr_sel;
    s_next.ch2_addr_wr = i_chan_addr_wr & addr_sel;

    // A disabled interface reports no channel 3 address match while channel3_enable is low.
    s_next.kcs_match  = i_kcs_addr_hit & kcs_active;
    s_next.smic_match = i_smic_addr_hit & smic_active;

    // The long code stalls the host longer than the short one.
    s_next.bt_wait_code = wait_sel ? `BT_LONG_WAIT : `BT_SHORT_WAIT;
  end

  // State register.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_reg.ctrl          <= `CTRL_RESET;
      s_reg.host_if_ctrl0 <= `HOST_IF_CTRL0_RESET;
      s_reg.rdata         <= `RDATA_RESET;
      s_reg.ch1_addr_wr   <= 1'b0;
      s_reg.ch2_addr_wr   <= 1'b0;
      s_reg.kcs_match     <= 1'b0;
      s_reg.smic_match    <= 1'b0;
      s_reg.bt_wait_code  <= `BT_SHORT_WAIT;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register.
  assign o_reg_rdata              = s_reg.rdata;
  assign o_channel1_address_wr    = s_reg.ch1_addr_wr;
  assign o_channel2_address_wr    = s_reg.ch2_addr_wr;
  assign o_kcs_match              = s_reg.kcs_match;
  assign o_smic_match             = s_reg.smic_match;
  assign o_bt_wait_code           = s_reg.bt_wait_code;
  assign o_address_channel_select = addr_sel;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  // A read of the monitor register in one cycle.
  sequence s_read_monitor;
    i_reg_rd && addr_is(i_reg_addr, `OFF_PIN_MONITOR);
  endsequence

  // A read of the monitor register in the same cycle as a stable pin set.
  sequence s_pins_then_read;
    $stable(pins_sync) ##0 s_read_monitor;
  endsequence

  a_pin_monitor_read: assert property (
    s_pins_then_read |=> (o_reg_rdata == $past(pins_sync)))
    else $error("pin monitor read returned wrong levels");

  a_ch1_steer: assert property (
    (i_chan_addr_wr && !addr_sel) |=> (o_channel1_address_wr && !o_channel2_address_wr))
    else $error("address setting not steered to channel 1");

  a_ch2_steer: assert property (
    (i_chan_addr_wr && addr_sel) |=> (o_channel2_address_wr && !o_channel1_address_wr))
    else $error("address setting not steered to channel 2");

  a_bt_wait_code: assert property (
    ##1 (o_bt_wait_code == ($past(wait_sel) ? 4'h6 : 4'h5)))
    else $error("BT wait code does not follow the wait select bit");

  a_kcs_enable_effect: assert property (
    (!s_reg.host_if_ctrl0[`CH3_ENABLE_BIT] && i_kcs_addr_hit)
      |=> (o_kcs_match == $past(s_reg.ctrl[`CTRL_KCS_EN_BIT])))
    else $error("KCS enable bit not honoured");

  a_kcs_blocked: assert property (
    !kcs_active |=> !o_kcs_match)
    else $error("KCS match while KCS disabled");

  a_smic_enable_effect: assert property (
    (!s_reg.host_if_ctrl0[`CH3_ENABLE_BIT] && i_smic_addr_hit)
      |=> (o_smic_match == $past(s_reg.ctrl[`CTRL_SMIC_EN_BIT])))
    else $error("SMIC enable bit not honoured");

  a_smic_blocked: assert property (
    !smic_active |=> !o_smic_match)
    else $error("SMIC match while SMIC disabled");

  // With channel3_enable high the enable bits are ignored, so every hit passes.
  a_kcs_ungated: assert property (
    (s_reg.host_if_ctrl0[`CH3_ENABLE_BIT] && i_kcs_addr_hit) |=> o_kcs_match)
    else $error("KCS hit lost while channel 3 enable is high");

  a_smic_ungated: assert property (
    (s_reg.host_if_ctrl0[`CH3_ENABLE_BIT] && i_smic_addr_hit) |=> o_smic_match)
    else $error("SMIC hit lost while channel 3 enable is high");

  // Read data fall back to zero outside the answer cycle, so stale values never linger.
  a_rdata_idle: assert property (
    !i_reg_rd |=> (o_reg_rdata == `RDATA_RESET))
    else $error("read data not zero outside the answer cycle");

endmodule // lpc_host_if_pin_monitor_ctrl

/* File: hw/lpc_pin_monitor_ctrl_defines.svh */
// Offsets, field positions, reset values and codes of the pin monitor and control bank.
`ifndef LPC_PIN_MONITOR_CTRL_DEFINES_SVH
`define LPC_PIN_MONITOR_CTRL_DEFINES_SVH

// Register offsets on the local register port.
`define OFF_PIN_MONITOR      4'h0
`define OFF_CHANNEL_CTRL     4'h1
`define OFF_HOST_IF_CTRL0    4'h2

// Field positions in channel_select_and_ipmi_enable.
`define CTRL_ADDR_SEL_BIT    7
`define CTRL_RSVD_HI_BIT     6
`define CTRL_RSVD_LO_BIT     4
`define CTRL_BT_WAIT_BIT     3
`define CTRL_KCS_EN_BIT      2
`define CTRL_SMIC_EN_BIT     1

// Field position in host_if_control_zero.
`define CH3_ENABLE_BIT       0

// Reset values.
`define CTRL_RESET           8'h00
`define HOST_IF_CTRL0_RESET  8'h00
`define PIN_MONITOR_RESET    8'h00
`define RDATA_RESET          8'h00

// Wait codes returned in the synchronisation field in BT mode.
`define BT_SHORT_WAIT        4'h5
`define BT_LONG_WAIT         4'h6

`endif

/* File: hw/lpc_pin_monitor_ctrl_pkg.sv */
// Types shared by the pin monitor and control bank.
package lpc_pin_monitor_ctrl_pkg;

  // Whole registered state of the top module.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] host_if_ctrl0;
    logic [7:0] rdata;
    logic       ch1_addr_wr;
    logic       ch2_addr_wr;
    logic       kcs_match;
    logic       smic_match;
    logic [3:0] bt_wait_code;
  } bank_state_type;

endpackage

/* File: hw/pin_sync.sv */
// Two-stage synchroniser for a vector of pin levels.
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_type;

  sync_state_type s_reg;
  sync_state_type s_next;

  // The first stage feeds only the second stage, so metastability cannot leak.
  always_comb begin
    s_next      = s_reg;
    s_next.meta = i_async;
    s_next.sync = s_reg.meta;
  end

  // State register.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_sync = s_reg.sync;

endmodule // pin_sync

/* File: tb/lpc_host_model.sv */
// Behavioural LPC host side: drives pin levels, channel 3 address hits and the setting strobe.
`timescale 1ns/1ps

module lpc_host_model (
  input  wire logic       i_ref_clk,
  output logic      [7:0] o_pins,
  output logic            o_chan_addr_wr,
  output logic            o_kcs_hit,
  output logic            o_smic_hit
);
  // Idle levels: the active-low pins rest high and the strobes rest low.
  initial begin
    o_pins         = 8'hFF;
    o_chan_addr_wr = 1'b0;
    o_kcs_hit      = 1'b0;
    o_smic_hit     = 1'b0;
  end

  // Pin levels change just after an edge, so the synchroniser never sees them mid-edge.
  task automatic drive_pins(input logic [7:0] lvl);
    @(posedge i_ref_clk);
    o_pins <= lvl;
  endtask

  // One-cycle pulse of the chosen strobes; the design answers in the following cycle.
  task automatic pulse(input logic wr, input logic kcs, input logic smic);
    @(posedge i_ref_clk);
    o_chan_addr_wr <= wr;
    o_kcs_hit      <= kcs;
    o_smic_hit     <= smic;
    @(posedge i_ref_clk);
    o_chan_addr_wr <= 1'b0;
    o_kcs_hit      <= 1'b0;
    o_smic_hit     <= 1'b0;
  endtask
endmodule // lpc_host_model

/* File: tb/tb.sv */
// Self-checking testbench of the pin monitor and channel control bank.
`timescale 1ns/1ps

module tb;
  logic       i_ref_clk = 1'b0;
  logic       i_nrst    = 1'b0;
  logic [3:0] addr      = 4'h0;
  logic [7:0] wdata     = 8'h00;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic [7:0] rdata;
  logic [7:0] pins;
  logic       chan_wr, kcs_hit, smic_hit, ch1_wr, ch2_wr, kcs_m, smic_m, sel;
  logic [3:0] wait_code;
  int         bad_count   = 0;
  int         checks_done = 0;

  // Clock of 8 ns period.
  always #4 i_ref_clk = ~i_ref_clk;

  lpc_host_model i_lpc_host_model (.i_ref_clk(i_ref_clk), .o_pins(pins),
    .o_chan_addr_wr(chan_wr), .o_kcs_hit(kcs_hit), .o_smic_hit(smic_hit));

  lpc_host_if_pin_monitor_ctrl i_lpc_host_if_pin_monitor_ctrl (.i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_lframe_n(pins[7]), .i_clkrun_n(pins[6]),
    .i_serirq(pins[5]), .i_lreset_n(pins[4]), .i_lpcpd_n(pins[3]), .i_pme_n(pins[2]),
    .i_smi_output_pin_n(pins[1]), .i_sci_output_pin_n(pins[0]), .i_chan_addr_wr(chan_wr),
    .o_channel1_address_wr(ch1_wr), .o_channel2_address_wr(ch2_wr),
    .i_kcs_addr_hit(kcs_hit), .i_smic_addr_hit(smic_hit), .o_kcs_match(kcs_m),
    .o_smic_match(smic_m), .o_bt_wait_code(wait_code), .o_address_channel_select(sel));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe; the register updates at the edge that samples it.
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge i_ref_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge i_ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic t_reset_and_wait;
    logic [7:0] d;
    reg_rd(4'h1, d);
    check(d, 8'h00);
    check({4'h0, wait_code}, 8'h05);
    reg_wr(4'h1, 8'h08);
    reg_rd(4'h1, d);
    check(d, 8'h08);
    check({4'h0, wait_code}, 8'h06);
    reg_wr(4'h1, 8'h00);
    @(posedge i_ref_clk);
    #1 check({4'h0, wait_code}, 8'h05);
  endtask

  // Setting strobe must reach exactly one channel address register.
  task automatic t_steer;
    for (int s = 0; s < 2; s++) begin
      reg_wr(4'h1, s[0] ? 8'h80 : 8'h00);
      #1 check({7'h0, sel}, {7'h0, s[0]});
      i_lpc_host_model.pulse(1'b1, 1'b0, 1'b0);
      #1 check({6'h0, ch2_wr, ch1_wr}, s[0] ? 8'h02 : 8'h01);
    end
  endtask

  // Every combination of channel 3 enable, KCS enable and SMIC enable.
  task automatic t_gate;
    logic       c, k, m;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      c = i[2];
      k = i[1];
      m = i[0];
      reg_wr(4'h2, {7'h00, c});
      reg_wr(4'h1, {5'h00, k, m, 1'b0});
      i_lpc_host_model.pulse(1'b0, 1'b1, 1'b1);
      #1 check({6'h0, kcs_m, smic_m}, {6'h0, c | k, c | m});
    end
    // Only the channel 3 enable bit is kept; the other bits of that register read zero.
    reg_wr(4'h2, 8'hFF);
    reg_rd(4'h2, d);
    check(d, 8'h01);
  endtask

  // Two synchroniser stages plus the read register sit between a pin and the read data.
  task automatic t_pins;
    logic [7:0] d;
    logic [7:0] pat [2] = '{8'hA5, 8'h5A};
    foreach (pat[i]) begin
      i_lpc_host_model.drive_pins(pat[i]);
      repeat (4) @(posedge i_ref_clk);
      reg_wr(4'h0, 8'hFF);
      reg_rd(4'h0, d);
      check(d, pat[i]);
    end
    reg_wr(4'hF, 8'hFF);
    reg_rd(4'hF, d);
    check(d, 8'h00);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run is well under a few thousand cycles.
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    t_reset_and_wait();
    t_steer();
    t_gate();
    t_pins();
    print_verdict();
  end
endmodule // tb
